/* File: inc/pdsr_pkg.sv */
// constants for the programmable delay shift register
package pdsr_pkg;
  // ----------------------------------------
  // data and control widths
  // ----------------------------------------
  localparam int PDSR_DATA_W = 8;
  localparam int PDSR_CODE_W = 4;
  localparam int PDSR_SEL_W = 5;
  // ----------------------------------------
  // stage counts
  // ----------------------------------------
  localparam logic [4:0] PDSR_SINGLE_BASE = 5'h01;
  localparam logic [4:0] PDSR_SPLIT_BASE = 5'h03;
  localparam logic [4:0] PDSR_SPLIT_FIXED = 5'h12;
  localparam int PDSR_MAX_STAGES = 18;
  // ----------------------------------------
  // reset values and warm-up for checking
  // ----------------------------------------
  localparam logic [3:0] PDSR_CODE_RST = 4'h0;
  localparam logic PDSR_SPLIT_RST = 1'b0;
  localparam logic [7:0] PDSR_OUT_RST = 8'h00;
  localparam logic [4:0] PDSR_WARM_MAX = 5'h1F;
  localparam logic [4:0] PDSR_WARM_OK = 5'h14;
endpackage

/* File: rtl/pdsr_delay_line.sv */
// byte-wide programmable length delay line, single-group or split variant
`timescale 1ns/10ps

// Functional notes
// [R1] every data bit reaches its output unchanged, only delayed
// [R2] single-group variant delays all eight bits by one common length
// [R3] output delay is programmable in stages
// [R4] all sampling and updates on the rising clock edge; reset clears control and output registers asynchronously
// [R5] length code is registered; new delay shows on the following edge
// [R6] single-group: delay is code plus one, 1 to 16 stages
// [R7] split: code plus three; split high fixes upper nibble at 18
// [R8] split-mode input picks equal delays or upper nibble held at 18
// [R9] length code and split mode registered with data on positive edge
// [R10] N stages: captured data appear after the N-th following edge; stages never reset
module pdsr_delay_line
  import pdsr_pkg::*;
#(
  parameter int SPLIT_VARIANT = 0,
  parameter int DATA_W = PDSR_DATA_W
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [DATA_W-1:0] byte_in,
  input wire logic [PDSR_CODE_W-1:0] delay_length_code_in,
  input wire logic split_nibble_select_in,
  output logic [DATA_W-1:0] byte_out
);

  localparam int HALF_W = DATA_W / 2;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (SPLIT_VARIANT != 0 && SPLIT_VARIANT != 1) begin : g_bad_variant
    $error("SPLIT_VARIANT must be 0 or 1");
  end
  if (DATA_W < 2 || (DATA_W % 2) != 0) begin : g_bad_width
    $error("DATA_W must be even and at least 2");
  end

  // ----------------------------------------
  // length decode
  // ----------------------------------------
  function automatic logic [PDSR_SEL_W-1:0] stage_index(input logic [PDSR_CODE_W-1:0] code,
                                                        input logic [PDSR_SEL_W-1:0] base);
    logic [PDSR_SEL_W-1:0] n;
    n = {1'b0, code} + base;
    stage_index = n - 5'h01;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [PDSR_CODE_W-1:0] len_r;
  logic [PDSR_CODE_W-1:0] len_nxt;
  logic split_r;
  logic split_nxt;
  logic [DATA_W-1:0] out_r;
  logic [DATA_W-1:0] out_nxt;
  logic [4:0] warm_r;
  logic [4:0] warm_nxt;
  // hist_r[k] holds the byte captured k edges before the newest capture
  logic [DATA_W-1:0] hist_r [PDSR_MAX_STAGES];
  logic [DATA_W-1:0] hist_nxt [PDSR_MAX_STAGES];
  logic [PDSR_SEL_W-1:0] lo_sel;
  logic [PDSR_SEL_W-1:0] hi_sel;

  // ----------------------------------------
  // control registers and output select
  // ----------------------------------------
  always_comb begin
    len_nxt = delay_length_code_in; // see [R5] see [R9]
    // the single-group part has no split pin; tie the mode low there
    split_nxt = (SPLIT_VARIANT == 1) ? split_nibble_select_in : 1'b0; // see [R9]
    if (SPLIT_VARIANT == 1) begin
      lo_sel = stage_index(len_r, PDSR_SPLIT_BASE); // see [R7]
    end else begin
      lo_sel = stage_index(len_r, PDSR_SINGLE_BASE); // see [R6]
    end
    if (split_r) begin
      hi_sel = PDSR_SPLIT_FIXED - 5'h01; // see [R7] see [R8]
    end else begin
      hi_sel = lo_sel; // see [R2]
    end
    // bits pass untouched; only the tap differs per nibble
    out_nxt = {hist_r[hi_sel][DATA_W-1:HALF_W], hist_r[lo_sel][HALF_W-1:0]}; // see [R1] see [R3]
    warm_nxt = (warm_r == PDSR_WARM_MAX) ? warm_r : warm_r + 5'h01;
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin // see [R4]
    if (rst_in) begin
      len_r <= PDSR_CODE_RST;
      split_r <= PDSR_SPLIT_RST;
      out_r <= PDSR_OUT_RST[DATA_W-1:0];
      warm_r <= 5'h00;
    end else begin
      len_r <= len_nxt;
      split_r <= split_nxt;
      out_r <= out_nxt;
      warm_r <= warm_nxt;
    end
  end

  // ----------------------------------------
  // data stages
  // ----------------------------------------
  // no reset here: a reset would need a clear on every stage for no gain
  always_comb begin
    hist_nxt[0] = byte_in;
    for (int i = 1; i < PDSR_MAX_STAGES; i++) begin
      hist_nxt[i] = hist_r[i-1];
    end
  end

  always_ff @(posedge core_clk_in) begin // see [R10]
    hist_r <= hist_nxt;
  end

  assign byte_out = out_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_len_capture;
    @(posedge core_clk_in) disable iff (rst_in)
      $past(!rst_in) |-> len_r == $past(delay_length_code_in);
  endproperty
  a_len_capture: assert property (p_len_capture) else $error("length code not registered"); // see [R5]

  property p_split_capture;
    @(posedge core_clk_in) disable iff (rst_in)
      ($past(!rst_in) && SPLIT_VARIANT == 1) |-> split_r == $past(split_nibble_select_in);
  endproperty
  a_split_capture: assert property (p_split_capture) else $error("split mode not registered"); // see [R9]

  property p_single_min;
    @(posedge core_clk_in) disable iff (rst_in)
      (SPLIT_VARIANT == 0 && warm_r >= PDSR_WARM_OK && $past(len_r) == 4'h0)
        |-> byte_out == $past(byte_in, 2);
  endproperty
  a_single_min: assert property (p_single_min) else $error("code 0 not one stage"); // see [R6]

  property p_single_max;
    @(posedge core_clk_in) disable iff (rst_in)
      (SPLIT_VARIANT == 0 && warm_r >= PDSR_WARM_OK && $past(len_r) == 4'hF)
        |-> byte_out == $past(byte_in, 17);
  endproperty
  a_single_max: assert property (p_single_max) else $error("code F not sixteen stages"); // see [R2]

  property p_single_mid;
    @(posedge core_clk_in) disable iff (rst_in)
      (SPLIT_VARIANT == 0 && warm_r >= PDSR_WARM_OK && $past(len_r) == 4'h7)
        |-> byte_out == $past(byte_in, 9);
  endproperty
  a_single_mid: assert property (p_single_mid) else $error("code 7 not eight stages"); // see [R3]

  property p_split_equal;
    @(posedge core_clk_in) disable iff (rst_in)
      (SPLIT_VARIANT == 1 && warm_r >= PDSR_WARM_OK && $past(len_r) == 4'h0 && !$past(split_r))
        |-> byte_out == $past(byte_in, 4);
  endproperty
  a_split_equal: assert property (p_split_equal) else $error("split code 0 not three stages"); // see [R7]

  property p_split_high_fixed;
    @(posedge core_clk_in) disable iff (rst_in)
      (SPLIT_VARIANT == 1 && warm_r >= PDSR_WARM_OK && $past(split_r))
        |-> byte_out[DATA_W-1:HALF_W] == $past(byte_in[DATA_W-1:HALF_W], 19);
  endproperty
  a_split_high_fixed: assert property (p_split_high_fixed) else $error("upper nibble not 18"); // see [R8]

  property p_split_low_follows;
    @(posedge core_clk_in) disable iff (rst_in)
      (SPLIT_VARIANT == 1 && warm_r >= PDSR_WARM_OK && $past(split_r) && $past(len_r) == 4'h1)
        |-> byte_out[HALF_W-1:0] == $past(byte_in[HALF_W-1:0], 5);
  endproperty
  a_split_low_follows: assert property (p_split_low_follows) else $error("lower nibble wrong"); // see [R7]

  property p_new_code_next_edge;
    @(posedge core_clk_in) disable iff (rst_in)
      (SPLIT_VARIANT == 0 && warm_r >= PDSR_WARM_OK && delay_length_code_in == 4'h2)
        ##1 1'b1 |=> byte_out == $past(byte_in, 4);
  endproperty
  a_new_code_next_edge: assert property (p_new_code_next_edge) else $error("code late"); // see [R10]

  property p_stage_shift;
    @(posedge core_clk_in) disable iff (rst_in)
      warm_r >= PDSR_WARM_OK |-> hist_r[PDSR_MAX_STAGES-1] == $past(byte_in, PDSR_MAX_STAGES);
  endproperty
  a_stage_shift: assert property (p_stage_shift) else $error("stages altered data"); // see [R1] see [R4]

endmodule

/* File: tb/pdsr_src.sv */
// upstream source model: random bytes and length controls
`timescale 1ns/10ps
module pdsr_src
  import pdsr_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rand_ctl_in,
  input wire logic [PDSR_CODE_W-1:0] code_in,
  input wire logic sel_in,
  output logic [PDSR_DATA_W-1:0] byte_out,
  output logic [PDSR_CODE_W-1:0] code_out,
  output logic sel_out
);
  // seeded in the same thread that draws, so the seed really applies
  initial begin
    void'($urandom(54216));
    byte_out = 8'h00;
    code_out = 4'h0;
    sel_out = 1'b0;
    forever begin
      @(posedge core_clk_in);
      byte_out <= 8'($urandom);
      code_out <= rand_ctl_in ? 4'($urandom) : code_in;
      sel_out <= rand_ctl_in ? 1'($urandom) : sel_in;
    end
  end
endmodule

/* File: tb/tb.sv */
// testbench: both variants against a queue model of the delay line
`timescale 1ns/10ps
module tb
  import pdsr_pkg::*;
;
  logic clk, rst, rnd, sel, sel_d;
  logic [3:0] code, code_d;
  logic [7:0] din, dout_s, dout_p;
  logic [7:0] hin[$];
  int hcode[$];
  bit hsel[$];
  int error_cnt, n_checks, since, rcnt, c;
  pdsr_src src (.core_clk_in(clk), .rand_ctl_in(rnd), .code_in(code), .sel_in(sel),
    .byte_out(din), .code_out(code_d), .sel_out(sel_d));
  pdsr_delay_line #(.SPLIT_VARIANT(0)) uut (.core_clk_in(clk), .rst_in(rst), .byte_in(din),
    .delay_length_code_in(code_d), .split_nibble_select_in(sel_d), .byte_out(dout_s));
  pdsr_delay_line #(.SPLIT_VARIANT(1)) uut_split (.core_clk_in(clk), .rst_in(rst),
    .byte_in(din), .delay_length_code_in(code_d), .split_nibble_select_in(sel_d),
    .byte_out(dout_p));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------
  // model: out seen at edge t is input of edge t-1-N, N from code of t-2
  // ----------------------------------------
  always @(posedge clk) begin
    hin.push_front(din);
    hcode.push_front(rst ? 0 : int'(code_d));
    hsel.push_front(rst ? 1'b0 : sel_d);
    if (hin.size() > 24) begin
      void'(hin.pop_back());
      void'(hcode.pop_back());
      void'(hsel.pop_back());
    end
    if (rst) begin
      if (rcnt > 0) begin
        chk("single reset", PDSR_OUT_RST, dout_s);
        chk("split reset", PDSR_OUT_RST, dout_p);
      end
      rcnt++;
      since = 0;
    end else begin
      rcnt = 0;
      since++;
    end
    // stages are never reset, so wait for a full history first
    if (since >= 20) begin
      c = hcode[2];
      chk("single out", hin[c + 2], dout_s);
      chk("split low", {4'h0, hin[c + 4][3:0]}, {4'h0, dout_p[3:0]});
      chk("split high", {4'h0, hsel[2] ? hin[19][7:4] : hin[c + 4][7:4]},
        {4'h0, dout_p[7:4]});
    end
  end
  initial begin
    rst = 1'b1;
    rnd = 1'b0;
    code = 4'h0;
    sel = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    since = 0;
    rcnt = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 16; k++) begin
        code <= 4'(k);
        sel <= s[0];
        repeat (24) @(posedge clk);
      end
      $display("fixed codes, split %0d done, mismatches %0d", s, error_cnt);
    end
    rnd <= 1'b1;
    repeat (400) @(posedge clk);
    $display("per-cycle random controls done, mismatches %0d", error_cnt);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rnd <= 1'b0;
    code <= 4'hF;
    sel <= 1'b1;
    repeat (60) @(posedge clk);
    $display("mid-run reset done, mismatches %0d", error_cnt);
    wrap_up();
  end
endmodule
